// [src/lbr_pkg.sv]
// Shared constants and types for the large byte-write RAM block
package lbr_pkg;
	localparam int LBR_AW = 16;
	localparam int LBR_DW = 72;
	localparam int LBR_LANES = 8;
	localparam int LBR_LW = 9;
	localparam int LBR_BANKS = 2;
	localparam int LBR_ROWS = 4096;
	localparam int LBR_IW = 12;
	localparam int LBR_RW = 13;
	localparam logic [7:0] LBR_BE_RST = 8'hff;
	localparam logic [71:0] LBR_DATA_RST = 72'h0;
	localparam logic [15:0] LBR_ADDR_RST = 16'h0;
	localparam logic [7:0] LBR_SPAN_18 = 8'h03;
	localparam int LBR_GO_LAT = 1;

	typedef enum logic [2:0] {
		LBR_W9,
		LBR_W18,
		LBR_W36,
		LBR_W72,
		LBR_W144
	} lbr_width_e;
endpackage

// [src/lbr_port_if.sv]
// Registered port request and array read answer between port and core
`timescale 1ns/1ps
interface lbr_port_if;
	logic [15:0] addr;
	logic [71:0] wdata;
	logic [7:0] be;
	logic we;
	logic go;
	logic rd_load;
	logic [71:0] rdata;

	modport regs (
		output addr,
		output wdata,
		output be,
		output we,
		output go,
		input rd_load,
		input rdata
	);
	modport core (
		input addr,
		input wdata,
		input be,
		input we,
		input go,
		output rd_load,
		output rdata
	);
endinterface

// [src/lbr_port_regs.sv]
// Per-port input registers, read latch and optional output register
`timescale 1ns/1ps
module lbr_port_regs
	import lbr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Port clocking
	input wire logic tick_own_i,
	input wire logic tick_oth_i,
	input wire logic in_sel_i,
	input wire logic out_sel_i,
	input wire logic indep_i,
	input wire logic ce_i,
	input wire logic clr_i,
	input wire logic out_reg_i,
	// User request
	input wire logic [15:0] addr_i,
	input wire logic [71:0] wdata_i,
	input wire logic [7:0] be_i,
	input wire logic we_i,
	output logic [71:0] dout_o,
	// Towards the array
	lbr_port_if.regs prt
);
	logic [15:0] addr_ff;
	logic [71:0] wdata_ff;
	logic [7:0] be_ff;
	logic we_ff;
	logic go_ff;
	logic [71:0] rd_ff;
	logic [71:0] out_ff;
	wire in_tick;
	wire out_tick;
	wire cap;

	// Independent mode pins both stages to the port's own clock
	assign in_tick = (indep_i || !in_sel_i) ? tick_own_i : tick_oth_i; // [R13] [R16]
	assign out_tick = (indep_i || !out_sel_i) ? tick_own_i : tick_oth_i; // [R12] [R16]
	assign cap = in_tick && ce_i; // [R19]

	// Clear acts on the next system clock edge, without waiting for a port clock edge
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || clr_i) begin // [R17] [R18]
			addr_ff <= LBR_ADDR_RST;
			wdata_ff <= LBR_DATA_RST;
			be_ff <= LBR_BE_RST;
			we_ff <= 1'b0;
			go_ff <= 1'b0;
		end else begin
			go_ff <= cap;
			if (cap) begin
				addr_ff <= addr_i;
				wdata_ff <= wdata_i;
				be_ff <= be_i;
				we_ff <= we_i; // [R10]
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || clr_i) begin // [R18]
			rd_ff <= LBR_DATA_RST;
			out_ff <= LBR_DATA_RST;
		end else begin
			if (prt.rd_load)
				rd_ff <= prt.rdata;
			if (out_tick && ce_i) // [R19]
				out_ff <= rd_ff;
		end
	end

	assign dout_o = out_reg_i ? out_ff : rd_ff; // [R14]
	assign prt.addr = addr_ff;
	assign prt.wdata = wdata_ff;
	assign prt.be = be_ff;
	assign prt.we = we_ff;
	assign prt.go = go_ff;

	sequence s_capture;
		cap && !clr_i ##1 go_ff;
	endsequence
	property p_capture;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		cap && !clr_i |-> s_capture;
	endproperty
	a_capture: assert property (p_capture) // [R13]
		else $error("input tick with enable did not raise go");
	property p_ce_hold;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		!ce_i && !clr_i |=> !go_ff && $stable(addr_ff) && $stable(we_ff);
	endproperty
	a_ce_hold: assert property (p_ce_hold) // [R19]
		else $error("port registers moved with clock enable low");
	property p_clear;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		clr_i |=> !go_ff && dout_o == LBR_DATA_RST;
	endproperty
	a_clear: assert property (p_clear) // [R18]
		else $error("port clear left state behind");
	property p_bypass;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		prt.rd_load && !out_reg_i && !clr_i |=> dout_o == $past(prt.rdata);
	endproperty
	a_bypass: assert property (p_bypass) // [R14]
		else $error("bypassed read data not on output");
	property p_out_reg;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		out_tick && ce_i && out_reg_i && !clr_i |=> dout_o == $past(rd_ff);
	endproperty
	a_out_reg: assert property (p_out_reg) // [R12]
		else $error("output register missed its clock");
endmodule

// [src/lbr_top.sv]
// Dual-port byte-write RAM with masked writes and per-port clocking
// What this block does
// [R1] A write commits only when the select says write, gated by lane mask.
// [R2] Lane mask defaults to all ones, leaving the select alone in charge.
// [R3] Lane masking applies at 18, 36 and 72 bit widths.
// [R4] The 144-bit simple dual-port mode joins both masks into sixteen bits.
// [R5] Mask bit i gates data bits 9i+8 down to 9i.
// [R6] In 144-bit mode mask bit i gates bits 9i+8 down to 9i, up to 143.
// [R7] Any mask pattern, sparse or empty, writes exactly the chosen lanes.
// [R8] In 8-bit lane widths the mask gates consecutive bytes instead.
// [R9] Unselected lanes keep their previous contents.
// [R10] No read enable: the select alone picks read or write.
// [R11] The 144-bit shape is refused outside simple dual-port use.
// [R12] Input and output registers may run on different clocks.
// [R13] All input registers capture on one clock picked from the two.
// [R14] The output register may be bypassed.
// [R15] Each port has 72 data inputs and 72 data outputs.
// [R16] In independent mode each port's registers use that port's clock.
// [R17] Each port has its own clock enable and clear.
// [R18] Every datapath register clears through its port's clear.
// [R19] With clock enable low a port holds and commits nothing; its read latch still loads on rd_load, which in 144-bit mode follows port B.
`timescale 1ns/1ps
module lbr_top
	import lbr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Configuration
	input wire logic sdp_i,
	input wire logic indep_i,
	input lbr_width_e width_a_i,
	input lbr_width_e width_b_i,
	input wire logic byte8_a_i,
	input wire logic byte8_b_i,
	input wire logic in_sel_a_i,
	input wire logic out_sel_a_i,
	input wire logic in_sel_b_i,
	input wire logic out_sel_b_i,
	input wire logic out_reg_a_i,
	input wire logic out_reg_b_i,
	output logic cfg_err_o,
	// Port A
	input wire logic tick_a_i,
	input wire logic ce_a_i,
	input wire logic clr_a_i,
	input wire logic [15:0] addr_a_i,
	input wire logic [71:0] data_a_i,
	input logic [7:0] be_a_i = LBR_BE_RST, // [R2]
	input wire logic we_a_i,
	output logic [71:0] q_a_o,
	// Port B
	input wire logic tick_b_i,
	input wire logic ce_b_i,
	input wire logic clr_b_i,
	input wire logic [15:0] addr_b_i,
	input wire logic [71:0] data_b_i,
	input logic [7:0] be_b_i = LBR_BE_RST, // [R2]
	input wire logic we_b_i,
	output logic [71:0] q_b_o
);
	function automatic logic [2:0] lane_off(input logic [15:0] a,
		input lbr_width_e w);
		unique case (w)
			LBR_W9: lane_off = a[2:0];
			LBR_W18: lane_off = {a[1:0], 1'b0};
			LBR_W36: lane_off = {a[0], 2'b00};
			default: lane_off = 3'h0;
		endcase
	endfunction

	function automatic logic [12:0] row_of(input logic [15:0] a,
		input lbr_width_e w);
		unique case (w)
			LBR_W9: row_of = a[15:3];
			LBR_W18: row_of = a[14:2];
			LBR_W36: row_of = a[13:1];
			LBR_W72: row_of = a[12:0];
			default: row_of = {a[11:0], 1'b0};
		endcase
	endfunction

	// Lanes a port owns; at 9 bits the mask does not exist
	function automatic logic [7:0] lane_en(input lbr_width_e w,
		input logic [7:0] be);
		unique case (w)
			LBR_W9: lane_en = 8'h01; // [R3]
			LBR_W18: lane_en = be & LBR_SPAN_18; // [R3] [R5]
			LBR_W36: lane_en = be & 8'h0f; // [R5]
			default: lane_en = be; // [R5] [R6]
		endcase
	endfunction

	function automatic logic [71:0] lane_bits(input logic [7:0] en);
		for (int i = 0; i < LBR_LANES; i++)
			lane_bits[i*LBR_LW +: LBR_LW] = {LBR_LW{en[i]}}; // [R5]
	endfunction

	// Byte widths put data byte i in lane i; the ninth bit stays zero
	function automatic logic [71:0] pack8(input logic [71:0] d,
		input logic b8);
		pack8 = d;
		if (b8) begin
			for (int i = 0; i < LBR_LANES; i++)
				pack8[i*LBR_LW +: LBR_LW] = {1'b0, d[i*8 +: 8]}; // [R8]
		end
	endfunction

	function automatic logic [71:0] unpack8(input logic [71:0] l,
		input logic b8);
		unpack8 = l;
		if (b8) begin
			unpack8 = LBR_DATA_RST;
			for (int i = 0; i < LBR_LANES; i++)
				unpack8[i*8 +: 8] = l[i*LBR_LW +: 8]; // [R8]
		end
	endfunction

	logic [71:0] mem_ff [LBR_BANKS][LBR_ROWS];
	logic cfg_err_ff;
	logic [7:0] wen_a [LBR_BANKS];
	logic [7:0] wen_b [LBR_BANKS];
	logic [71:0] wd_a [LBR_BANKS];
	logic [71:0] wd_b [LBR_BANKS];

	lbr_port_if pa ();
	lbr_port_if pb ();

	lbr_port_regs u_port_a (
		.clk_sys_i (clk_sys_i),
		.rst_b_i (rst_b_i),
		.tick_own_i (tick_a_i),
		.tick_oth_i (tick_b_i),
		.in_sel_i (in_sel_a_i),
		.out_sel_i (out_sel_a_i),
		.indep_i (indep_i),
		.ce_i (ce_a_i),
		.clr_i (clr_a_i),
		.out_reg_i (out_reg_a_i),
		.addr_i (addr_a_i),
		.wdata_i (data_a_i),
		.be_i (be_a_i),
		.we_i (we_a_i),
		.dout_o (q_a_o),
		.prt (pa.regs)
	);
	lbr_port_regs u_port_b (
		.clk_sys_i (clk_sys_i),
		.rst_b_i (rst_b_i),
		.tick_own_i (tick_b_i),
		.tick_oth_i (tick_a_i),
		.in_sel_i (in_sel_b_i),
		.out_sel_i (out_sel_b_i),
		.indep_i (indep_i),
		.ce_i (ce_b_i),
		.clr_i (clr_b_i),
		.out_reg_i (out_reg_b_i),
		.addr_i (addr_b_i),
		.wdata_i (data_b_i),
		.be_i (be_b_i),
		.we_i (we_b_i),
		.dout_o (q_b_o),
		.prt (pb.regs)
	);

	// Only 144 output drivers exist, so a wide port needs both halves
	wire wide_a = (width_a_i == LBR_W144);
	wire wide_b = (width_b_i == LBR_W144);
	wire m144 = wide_a && wide_b && sdp_i;
	wire cfg_bad = (wide_a || wide_b) && !m144; // [R11]

	wire [12:0] row_a = row_of(pa.addr, width_a_i);
	wire [12:0] row_b = row_of(pb.addr, width_b_i);
	wire [2:0] off_a = lane_off(pa.addr, width_a_i);
	wire [2:0] off_b = lane_off(pb.addr, width_b_i);
	wire [11:0] idx_a = m144 ? pa.addr[11:0] : row_a[12:1];
	wire [11:0] idx_b = m144 ? pb.addr[11:0] : row_b[12:1];
	wire [7:0] ln_a = 8'(lane_en(width_a_i, pa.be) << off_a);
	wire [7:0] ln_b = 8'(lane_en(width_b_i, pb.be) << off_b);
	wire [71:0] pk_a = pack8(pa.wdata, byte8_a_i);
	wire [71:0] pk_b = pack8(pb.wdata, byte8_b_i);
	wire [71:0] sh_a = pk_a << (LBR_LW * off_a);
	wire [71:0] sh_b = pk_b << (LBR_LW * off_b);

	// Simple dual-port 144: A side writes, B side reads
	wire commit_a = pa.go && pa.we && !cfg_bad; // [R1] [R10]
	wire commit_b = pb.go && pb.we && !cfg_bad && !m144; // [R1]
	wire rdgo_b = pb.go && !pb.we && !cfg_bad; // [R10]
	wire rdgo_a = m144 ? rdgo_b : (pa.go && !pa.we && !cfg_bad);

	always_comb begin
		for (int b = 0; b < LBR_BANKS; b++) begin
			wen_a[b] = 8'h00;
			wen_b[b] = 8'h00;
			wd_a[b] = sh_a;
			wd_b[b] = sh_b;
			if (commit_a && !m144 && row_a[0] == b[0])
				wen_a[b] = ln_a; // [R1] [R7]
			if (commit_b && row_b[0] == b[0])
				wen_b[b] = ln_b;
		end
		if (commit_a && m144) begin
			wen_a[0] = pa.be; // [R4] [R6]
			wen_a[1] = pb.be; // [R4] [R6]
			wd_a[0] = pk_a;
			wd_a[1] = pack8(pb.wdata, byte8_a_i);
		end
	end

	// Lane-wise update; collisions on one lane leave port B's value
	always_ff @(posedge clk_sys_i) begin
		for (int b = 0; b < LBR_BANKS; b++) begin
			for (int i = 0; i < LBR_LANES; i++) begin
				if (wen_a[b][i]) // [R9]
					mem_ff[b][idx_a][i*LBR_LW +: LBR_LW] <=
						wd_a[b][i*LBR_LW +: LBR_LW];
				if (wen_b[b][i]) // [R9]
					mem_ff[b][idx_b][i*LBR_LW +: LBR_LW] <=
						wd_b[b][i*LBR_LW +: LBR_LW];
			end
		end
	end

	wire [71:0] raw_a = mem_ff[row_a[0]][idx_a] >> (LBR_LW * off_a);
	wire [71:0] raw_b = mem_ff[row_b[0]][idx_b] >> (LBR_LW * off_b);
	wire [71:0] nar_a = raw_a & lane_bits(lane_en(width_a_i, LBR_BE_RST));
	wire [71:0] nar_b = raw_b & lane_bits(lane_en(width_b_i, LBR_BE_RST));

	assign pa.rd_load = rdgo_a;
	assign pb.rd_load = rdgo_b;
	assign pa.rdata = m144 ? unpack8(mem_ff[0][idx_b], byte8_a_i) :
		unpack8(nar_a, byte8_a_i);
	assign pb.rdata = m144 ? unpack8(mem_ff[1][idx_b], byte8_b_i) :
		unpack8(nar_b, byte8_b_i); // [R15]

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i)
			cfg_err_ff <= 1'b0;
		else
			cfg_err_ff <= cfg_bad; // [R11]
	end
	assign cfg_err_o = cfg_err_ff;

	// Helper copy of a port A row write, for lane checks
	logic chk_vld_ff;
	logic [71:0] chk_old_ff;
	logic [71:0] chk_new_ff;
	logic [71:0] chk_msk_ff;
	logic chk_bank_ff;
	logic [11:0] chk_idx_ff;
	wire chk_go = commit_a && !m144 && !pb.go;
	always_ff @(posedge clk_sys_i) begin
		chk_vld_ff <= rst_b_i && chk_go;
		chk_old_ff <= mem_ff[row_a[0]][idx_a];
		chk_new_ff <= sh_a;
		chk_msk_ff <= lane_bits(ln_a);
		chk_bank_ff <= row_a[0];
		chk_idx_ff <= idx_a;
	end
	wire [71:0] chk_now = mem_ff[chk_bank_ff][chk_idx_ff];

	sequence s_write_a;
		chk_go ##1 chk_vld_ff;
	endsequence
	property p_keep_lanes;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		s_write_a |-> (chk_now & ~chk_msk_ff) == (chk_old_ff & ~chk_msk_ff);
	endproperty
	a_keep_lanes: assert property (p_keep_lanes) // [R9]
		else $error("unselected lane changed on write");
	property p_set_lanes;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		s_write_a |-> (chk_now & chk_msk_ff) == (chk_new_ff & chk_msk_ff);
	endproperty
	a_set_lanes: assert property (p_set_lanes) // [R7]
		else $error("selected lane did not take write data");
	property p_read_no_write;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		pa.go && !pa.we |-> wen_a[0] == 8'h00 && wen_a[1] == 8'h00;
	endproperty
	a_read_no_write: assert property (p_read_no_write) // [R1]
		else $error("read cycle wrote the array");
	property p_x9_one_lane;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		commit_a && width_a_i == LBR_W9 |-> $onehot(ln_a);
	endproperty
	a_x9_one_lane: assert property (p_x9_one_lane) // [R3]
		else $error("9-bit write did not hit exactly one lane");
	property p_join144;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		commit_a && m144 |-> wen_a[0] == pa.be && wen_a[1] == pb.be;
	endproperty
	a_join144: assert property (p_join144) // [R4]
		else $error("wide mask not joined from both ports");
	property p_refuse144;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		cfg_bad |-> !(|{wen_a[0], wen_a[1], wen_b[0], wen_b[1]})
			##1 cfg_err_o;
	endproperty
	a_refuse144: assert property (p_refuse144) // [R11]
		else $error("refused wide shape still wrote or hid error");
endmodule

// [testbench/lbr_user_model.sv]
// Fabric-side user logic driving one port of the RAM
`timescale 1ns/1ps
module lbr_user_model (
	// Clock
	input wire logic clk_sys_i,
	// Port request
	output logic tick_o,
	output logic ce_o,
	output logic clr_o,
	output logic [15:0] addr_o,
	output logic [71:0] data_o,
	output logic [7:0] be_o,
	output logic we_o
);
	initial begin
		tick_o = 1'b0;
		ce_o = 1'b0;
		clr_o = 1'b0;
		addr_o = 16'h0;
		data_o = 72'h0;
		be_o = 8'hff;
		we_o = 1'b0;
	end

	// One request per call, held through its sampling edge
	task automatic req(input logic w, input logic en, input logic [15:0] a,
		input logic [71:0] d, input logic [7:0] m, input int gap);
		@(posedge clk_sys_i);
		tick_o <= 1'b1;
		ce_o <= en;
		we_o <= w;
		addr_o <= a;
		data_o <= d;
		be_o <= m;
		@(posedge clk_sys_i);
		// Released lines flip so stale values never pass as held ones
		tick_o <= 1'b0;
		ce_o <= ~en;
		we_o <= ~w;
		addr_o <= ~a;
		data_o <= ~d;
		be_o <= ~m;
		repeat (gap) @(posedge clk_sys_i);
	endtask

	task automatic clear();
		@(posedge clk_sys_i);
		clr_o <= 1'b1;
		@(posedge clk_sys_i);
		clr_o <= 1'b0;
	endtask
endmodule

// [testbench/lbr_top_test.sv]
// Self-checking bench for the byte-write RAM ports
`timescale 1ns/1ps
`define check(got, exp) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("mismatch at %0t got %h exp %h", $time, got, exp); \
	end \
end
module lbr_top_test
	import lbr_pkg::*;
;
	localparam logic [71:0] P1 = 72'hf0e1d2c3b4a5968778;
	localparam logic [71:0] P2 = 72'h0123456789abcdef55;
	logic clk_sys_i, rst_b_i, sdp, indep, br_a, br_b, ob, cfg_err, is_b;
	lbr_width_e wa, wb;
	logic tick_a, ce_a, clr_a, we_a, tick_b, ce_b, clr_b, we_b;
	logic [15:0] addr_a, addr_b;
	logic [71:0] data_a, data_b, q_a, q_b;
	logic [7:0] be_a, be_b;
	int mismatches, compares;

	lbr_top lbr_top_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.sdp_i(sdp), .indep_i(indep), .width_a_i(wa), .width_b_i(wb),
		.byte8_a_i(br_a), .byte8_b_i(br_b), .in_sel_a_i(1'b0),
		.out_sel_a_i(1'b0), .in_sel_b_i(is_b), .out_sel_b_i(1'b0),
		.out_reg_a_i(1'b0), .out_reg_b_i(ob), .cfg_err_o(cfg_err),
		.tick_a_i(tick_a), .ce_a_i(ce_a), .clr_a_i(clr_a),
		.addr_a_i(addr_a), .data_a_i(data_a), .be_a_i(be_a),
		.we_a_i(we_a), .q_a_o(q_a), .tick_b_i(tick_b), .ce_b_i(ce_b),
		.clr_b_i(clr_b), .addr_b_i(addr_b), .data_b_i(data_b),
		.be_b_i(be_b), .we_b_i(we_b), .q_b_o(q_b));
	lbr_user_model usr_a_inst (.clk_sys_i(clk_sys_i), .tick_o(tick_a),
		.ce_o(ce_a), .clr_o(clr_a), .addr_o(addr_a), .data_o(data_a),
		.be_o(be_a), .we_o(we_a));
	lbr_user_model usr_b_inst (.clk_sys_i(clk_sys_i), .tick_o(tick_b),
		.ce_o(ce_b), .clr_o(clr_b), .addr_o(addr_b), .data_o(data_b),
		.be_o(be_b), .we_o(we_b));

	function automatic logic [71:0] merge(input logic [71:0] o, n,
		input logic [7:0] m);
		merge = o;
		for (int i = 0; i < 8; i++) begin
			if (m[i]) begin
				merge[9*i +: 9] = n[9*i +: 9];
			end
		end
	endfunction

	task automatic wr_a(input logic [15:0] a, input logic [71:0] d,
		input logic [7:0] m);
		usr_a_inst.req(1'b1, 1'b1, a, d, m, 0);
	endtask

	// Bypassed read: latch is loaded one edge after capture
	task automatic rd_b(input logic [15:0] a);
		usr_b_inst.req(1'b0, 1'b1, a, 72'h0, 8'hff, 0);
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic t_mask();
		wr_a(16'h0005, P1, 8'hff);
		wr_a(16'h0005, P2, 8'h5a);
		wr_a(16'h0005, ~P1, 8'h00);
		rd_b(16'h0005);
		`check(q_b, merge(P1, P2, 8'h5a))
	endtask

	task automatic t_hold();
		usr_a_inst.req(1'b0, 1'b1, 16'h0005, P1, 8'hff, 0);
		usr_a_inst.req(1'b1, 1'b0, 16'h0005, P1, 8'hff, 1);
		#1;
		`check(q_a, merge(P1, P2, 8'h5a))
		rd_b(16'h0005);
		`check(q_b, merge(P1, P2, 8'h5a))
	endtask

	task automatic t_clear();
		usr_b_inst.clear();
		#1;
		`check(q_b, 72'h0)
		`check(q_a, merge(P1, P2, 8'h5a))
	endtask

	task automatic t_outreg();
		@(posedge clk_sys_i);
		ob <= 1'b1;
		wr_a(16'h0007, P2, 8'hff);
		rd_b(16'h0007);
		`check(q_b, 72'h0)
		rd_b(16'h0007);
		`check(q_b, P2)
		@(posedge clk_sys_i);
		ob <= 1'b0;
	endtask

	task automatic t_narrow();
		logic [71:0] exp;
		exp = P1;
		exp[27 +: 9] = P2[9 +: 9];
		exp[45 +: 9] = P2[0 +: 9];
		wr_a(16'h0000, P1, 8'hff);
		@(posedge clk_sys_i);
		wa <= LBR_W18;
		wr_a(16'h0001, P2, 8'h02);
		@(posedge clk_sys_i);
		wa <= LBR_W9;
		// Nine-bit port has no mask: an empty mask still writes its lane
		wr_a(16'h0005, P2, 8'h00);
		@(posedge clk_sys_i);
		wa <= LBR_W72;
		rd_b(16'h0000);
		`check(q_b, exp)
	endtask

	task automatic t_byte8();
		logic [71:0] exp;
		exp = 72'h0;
		for (int i = 0; i < 8; i++) begin
			exp[9*i +: 8] = P1[8*i +: 8];
		end
		@(posedge clk_sys_i);
		br_a <= 1'b1;
		wr_a(16'h0002, P1, 8'hff);
		@(posedge clk_sys_i);
		br_a <= 1'b0;
		rd_b(16'h0002);
		`check(q_b, exp)
		exp = {8'h00, P1[63:0]};
		@(posedge clk_sys_i);
		br_b <= 1'b1;
		rd_b(16'h0002);
		`check(q_b, exp)
		@(posedge clk_sys_i);
		br_b <= 1'b0;
	endtask

	task automatic t_cfg();
		@(posedge clk_sys_i);
		wa <= LBR_W144;
		repeat (3) @(posedge clk_sys_i);
		#1;
		`check(cfg_err, 1'b1)
		@(posedge clk_sys_i);
		wb <= LBR_W144;
		sdp <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#1;
		`check(cfg_err, 1'b0)
		@(posedge clk_sys_i);
		wa <= LBR_W72;
		wb <= LBR_W72;
		sdp <= 1'b0;
	endtask

	// Joined wide port: B's input registers follow A's tick
	task automatic t_wide();
		@(posedge clk_sys_i);
		indep <= 1'b0;
		is_b <= 1'b1;
		sdp <= 1'b1;
		wa <= LBR_W144;
		wb <= LBR_W144;
		fork
			usr_a_inst.req(1'b1, 1'b1, 16'h0009, P1, 8'hff, 0);
			usr_b_inst.req(1'b1, 1'b1, 16'h0009, P2, 8'hff, 0);
		join
		fork
			usr_a_inst.req(1'b1, 1'b1, 16'h0009, P2, 8'h81, 0);
			usr_b_inst.req(1'b1, 1'b1, 16'h0009, P1, 8'h3c, 0);
		join
		fork
			usr_a_inst.req(1'b0, 1'b1, 16'h0009, P1, 8'hff, 0);
			usr_b_inst.req(1'b0, 1'b1, 16'h0009, P1, 8'hff, 0);
		join
		repeat (2) @(posedge clk_sys_i);
		#1;
		`check(q_a, merge(P1, P2, 8'h81))
		`check(q_b, merge(P2, P1, 8'h3c))
		@(posedge clk_sys_i);
		indep <= 1'b1;
		is_b <= 1'b0;
		sdp <= 1'b0;
		wa <= LBR_W72;
		wb <= LBR_W72;
	endtask

	task automatic complete_run();
		if (mismatches == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		mismatches = 0;
		compares = 0;
		rst_b_i = 1'b0;
		sdp = 1'b0;
		indep = 1'b1;
		is_b = 1'b0;
		br_a = 1'b0;
		br_b = 1'b0;
		ob = 1'b0;
		wa = LBR_W72;
		wb = LBR_W72;
		repeat (6) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		t_mask();
		t_hold();
		t_clear();
		t_outreg();
		t_narrow();
		t_byte8();
		t_cfg();
		t_wide();
		complete_run();
	end
endmodule
